// ---- rtl/atm_consts.vh ----
// Purpose: offsets, field positions, reset values for accumulator/timebase/mux registers
// Assumes: 8-bit register port, byte addresses
// Notes: definitions only
`ifndef ATM_CONSTS_VH
`define ATM_CONSTS_VH
`define ATM_ADDR_ACC_COND_A 8'he1
`define ATM_ADDR_ACC_COND_B 8'he2
`define ATM_ADDR_DB_ONE 8'he4
`define ATM_ADDR_DB_TWO 8'he5
`define ATM_ADDR_TB_CTRL 8'he9
`define ATM_ADDR_S1_NEG 8'heb
`define ATM_ADDR_S1_POS 8'hec
`define ATM_ADDR_S2_NEG 8'hed
`define ATM_ADDR_S2_POS 8'hee
`define ATM_RST_ACC_COND 8'h00
`define ATM_RST_DB 8'h00
`define ATM_RST_TB_CTRL 8'h07
`define ATM_RST_MUX 5'h00
`define ATM_PRE_INTERNAL 3'h7
`define ATM_COND_ALWAYS 2'h0
`define ATM_COND_POS 2'h1
`define ATM_COND_NEG 2'h2
`define ATM_COND_NEVER 2'h3
`define ATM_MUX_GND 5'h00
`define ATM_MUX_LAST_VIN 5'h0c
`define ATM_MUX_RSVD_A 5'h15
`define ATM_MUX_LAST_VALID 5'h17
`define ATM_TB_PRE_LSB 0
`define ATM_TB_DIV_LSB 3
`endif

// ---- rtl/atm_cond.v ----
// Purpose: accumulation condition decode for one two-bit field
// Assumes: current is two's complement
// Notes: zero current counts as neither positive nor negative
`timescale 1ns/1ps
`include "atm_consts.vh"
module atm_cond
(
  // Field and sign
  input wire [1:0] cond,
  input wire cur_pos,
  input wire cur_neg,
  // Result
  output reg allow
);
  // Field decode
  always @*
  begin
    case (cond)
      `ATM_COND_ALWAYS: allow = 1'b1;
      `ATM_COND_POS: allow = cur_pos;
      `ATM_COND_NEG: allow = cur_neg;
      default: allow = 1'b0;
    endcase
  end
endmodule

// ---- rtl/atm_regs.v ----
// Purpose: accumulator condition, deadband, timebase and slot mux registers
// Assumes: synchronous 8-bit register port; one-cycle sample strobe
// Notes: accumulator datapath lives outside; this block issues enables
`timescale 1ns/1ps
`include "atm_consts.vh"
module atm_regs
(
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_hit,
  // Measurement samples
  input wire sample_valid,
  input wire [19:0] current_one,
  input wire [19:0] current_two,
  // Mode and fast selectors
  input wire fast_mode,
  input wire [4:0] fast_pos_code,
  input wire [4:0] fast_neg_code,
  input wire slot_advance,
  // Accumulator enables
  output reg acc_charge_one,
  output reg acc_energy_one,
  output reg acc_charge_two,
  output reg acc_energy_two,
  output reg acc_sum_charge_one,
  output reg acc_sum_charge_two,
  output reg acc_sum_energy_one,
  output reg acc_sum_energy_two,
  output reg threshold_check,
  // Timebase
  output reg tb_internal,
  output reg [2:0] tb_prescale,
  output reg [4:0] tb_divider,
  // Auxiliary channel selectors
  output reg [4:0] positive_selector,
  output reg [4:0] negative_selector,
  output reg selector_connect,
  output reg active_slot
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  reg [7:0] cond_a_q;
  reg [7:0] cond_b_q;
  reg [7:0] db_one_q;
  reg [7:0] db_two_q;
  reg [7:0] tb_ctrl_q;
  reg [4:0] s1_neg_q;
  reg [4:0] s1_pos_q;
  reg [4:0] s2_neg_q;
  reg [4:0] s2_pos_q;
  reg slot_q;

  // Writes; slot registers keep only the low five bits
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cond_a_q <= `ATM_RST_ACC_COND;
      cond_b_q <= `ATM_RST_ACC_COND;
      db_one_q <= `ATM_RST_DB;
      db_two_q <= `ATM_RST_DB;
      tb_ctrl_q <= `ATM_RST_TB_CTRL;
      s1_neg_q <= `ATM_RST_MUX;
      s1_pos_q <= `ATM_RST_MUX;
      s2_neg_q <= `ATM_RST_MUX;
      s2_pos_q <= `ATM_RST_MUX;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `ATM_ADDR_ACC_COND_A)
        cond_a_q <= reg_wdata;
      else if (reg_addr == `ATM_ADDR_ACC_COND_B)
        cond_b_q <= reg_wdata;
      else if (reg_addr == `ATM_ADDR_DB_ONE)
        db_one_q <= reg_wdata;
      else if (reg_addr == `ATM_ADDR_DB_TWO)
        db_two_q <= reg_wdata;
      else if (reg_addr == `ATM_ADDR_TB_CTRL)
        tb_ctrl_q <= reg_wdata;
      else if (reg_addr == `ATM_ADDR_S1_NEG)
        s1_neg_q <= reg_wdata[4:0];
      else if (reg_addr == `ATM_ADDR_S1_POS)
        s1_pos_q <= reg_wdata[4:0];
      else if (reg_addr == `ATM_ADDR_S2_NEG)
        s2_neg_q <= reg_wdata[4:0];
      else if (reg_addr == `ATM_ADDR_S2_POS)
        s2_pos_q <= reg_wdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  reg [7:0] rdata_d;
  reg hit_d;

  always @*
  begin
    hit_d = 1'b1;
    rdata_d = 8'h00;
    if (reg_addr == `ATM_ADDR_ACC_COND_A)
      rdata_d = cond_a_q;
    else if (reg_addr == `ATM_ADDR_ACC_COND_B)
      rdata_d = cond_b_q;
    else if (reg_addr == `ATM_ADDR_DB_ONE)
      rdata_d = db_one_q;
    else if (reg_addr == `ATM_ADDR_DB_TWO)
      rdata_d = db_two_q;
    else if (reg_addr == `ATM_ADDR_TB_CTRL)
      rdata_d = tb_ctrl_q;
    else if (reg_addr == `ATM_ADDR_S1_NEG)
      rdata_d = {3'h0, s1_neg_q};
    else if (reg_addr == `ATM_ADDR_S1_POS)
      rdata_d = {3'h0, s1_pos_q};
    else if (reg_addr == `ATM_ADDR_S2_NEG)
      rdata_d = {3'h0, s2_neg_q};
    else if (reg_addr == `ATM_ADDR_S2_POS)
      rdata_d = {3'h0, s2_pos_q};
    else
      hit_d = 1'b0;
  end

  // Read data registered; holds last value when no read
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rdata_d;
      reg_hit <= hit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sign and magnitude of each current
  wire pos_one = !current_one[19] && (current_one != 20'h00000);
  wire neg_one = current_one[19];
  wire pos_two = !current_two[19] && (current_two != 20'h00000);
  wire neg_two = current_two[19];
  // Two's complement magnitude; most negative value wraps, still huge in 20 bits
  wire [19:0] mag_one = neg_one ? (~current_one + 20'h00001) : current_one;
  wire [19:0] mag_two = neg_two ? (~current_two + 20'h00001) : current_two;
  // Deadband in current LSB units, zero-extended
  wire above_one = (mag_one >= {12'h000, db_one_q});
  wire above_two = (mag_two >= {12'h000, db_two_q});

  ////////////////////////////////////////////////////////////////////////////
  // Condition decoders, one per field
  wire ok_pair_one;
  wire ok_pair_two;
  wire ok_sc_one;
  wire ok_sc_two;
  wire ok_se_one;
  wire ok_se_two;

  // First control register fields
  atm_cond u_first_pair_cond
  (
    .cond(cond_a_q[1:0]),
    .cur_pos(pos_one),
    .cur_neg(neg_one),
    .allow(ok_pair_one)
  );

  atm_cond u_second_pair_cond
  (
    .cond(cond_a_q[3:2]),
    .cur_pos(pos_two),
    .cur_neg(neg_two),
    .allow(ok_pair_two)
  );

  // Second control register fields
  atm_cond u_sum_charge_cond_cur_one
  (
    .cond(cond_b_q[1:0]),
    .cur_pos(pos_one),
    .cur_neg(neg_one),
    .allow(ok_sc_one)
  );

  atm_cond u_sum_charge_cond_cur_two
  (
    .cond(cond_b_q[3:2]),
    .cur_pos(pos_two),
    .cur_neg(neg_two),
    .allow(ok_sc_two)
  );

  atm_cond u_sum_energy_cond_cur_one
  (
    .cond(cond_b_q[5:4]),
    .cur_pos(pos_one),
    .cur_neg(neg_one),
    .allow(ok_se_one)
  );

  atm_cond u_sum_energy_cond_cur_two
  (
    .cond(cond_b_q[7:6]),
    .cur_pos(pos_two),
    .cur_neg(neg_two),
    .allow(ok_se_two)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Accumulate enables: one-cycle pulses per sample
  reg any_update_d;

  always @*
  begin
    any_update_d = sample_valid &&
      ((above_one && (ok_pair_one || ok_sc_one || ok_se_one)) ||
       (above_two && (ok_pair_two || ok_sc_two || ok_se_two)));
  end

  // Sum enables follow the second control register fields of each current
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_charge_one <= 1'b0;
      acc_energy_one <= 1'b0;
      acc_charge_two <= 1'b0;
      acc_energy_two <= 1'b0;
      acc_sum_charge_one <= 1'b0;
      acc_sum_charge_two <= 1'b0;
      acc_sum_energy_one <= 1'b0;
      acc_sum_energy_two <= 1'b0;
      threshold_check <= 1'b0;
    end
    else
    begin
      acc_charge_one <= sample_valid && above_one && ok_pair_one;
      acc_energy_one <= sample_valid && above_one && ok_pair_one;
      acc_charge_two <= sample_valid && above_two && ok_pair_two;
      acc_energy_two <= sample_valid && above_two && ok_pair_two;
      acc_sum_charge_one <= sample_valid && above_one && ok_sc_one;
      acc_sum_charge_two <= sample_valid && above_two && ok_sc_two;
      acc_sum_energy_one <= sample_valid && above_one && ok_se_one;
      acc_sum_energy_two <= sample_valid && above_two && ok_se_two;
      // Same cycle as the update so the compare sees fresh totals
      threshold_check <= any_update_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timebase outputs
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tb_internal <= 1'b1;
      tb_prescale <= `ATM_PRE_INTERNAL;
      tb_divider <= 5'h00;
    end
    else
    begin
      tb_prescale <= tb_ctrl_q[`ATM_TB_PRE_LSB +: 3];
      tb_divider <= tb_ctrl_q[`ATM_TB_DIV_LSB +: 5];
      tb_internal <= (tb_ctrl_q[`ATM_TB_PRE_LSB +: 3] == `ATM_PRE_INTERNAL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot round robin; held at slot one in fast mode
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      slot_q <= 1'b0;
    else if (fast_mode)
      slot_q <= 1'b0;
    else if (slot_advance)
      slot_q <= !slot_q;
  end

  // Selector source; fast codes are assumed stable while converting
  reg [4:0] pos_d;
  reg [4:0] neg_d;
  reg valid_d;

  always @*
  begin
    if (fast_mode)
    begin
      pos_d = fast_pos_code;
      neg_d = fast_neg_code;
    end
    else if (slot_q)
    begin
      pos_d = s2_pos_q;
      neg_d = s2_neg_q;
    end
    else
    begin
      pos_d = s1_pos_q;
      neg_d = s1_neg_q;
    end
    // Reserved codes in either selector open the path
    valid_d = (pos_d <= `ATM_MUX_LAST_VALID) && (pos_d != `ATM_MUX_RSVD_A) &&
      (neg_d <= `ATM_MUX_LAST_VALID) && (neg_d != `ATM_MUX_RSVD_A);
  end

  // Independent codes driven to the analog switch decoder
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      positive_selector <= `ATM_MUX_GND;
      negative_selector <= `ATM_MUX_GND;
      selector_connect <= 1'b1;
      active_slot <= 1'b0;
    end
    else
    begin
      positive_selector <= pos_d;
      negative_selector <= neg_d;
      selector_connect <= valid_d;
      active_slot <= slot_q;
    end
  end

endmodule

// ---- sim/atm_regs_checker.sv ----
// Purpose: port assertions for the accumulator, timebase and selector registers
// Assumes: one clock domain, asynchronous active-low reset
// Notes: shadows of 0xe1/0xe4/0xe5 let deadband checks be judged at the ports
`timescale 1ns/1ps
module atm_regs_checker
(
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire reg_hit,
  // Samples and mode
  input wire sample_valid,
  input wire [19:0] current_one,
  input wire [19:0] current_two,
  input wire fast_mode,
  input wire [4:0] fast_pos_code,
  input wire [4:0] fast_neg_code,
  // Watched outputs
  input wire acc_charge_one,
  input wire acc_energy_one,
  input wire acc_charge_two,
  input wire threshold_check,
  input wire tb_internal,
  input wire [2:0] tb_prescale,
  input wire [4:0] positive_selector,
  input wire [4:0] negative_selector,
  input wire selector_connect,
  input wire active_slot
);
  reg [7:0] cond_a_q;
  reg [7:0] db_one_q;
  reg [7:0] db_two_q;
  // Magnitudes, zero-extended deadbands compare against these
  wire [19:0] mag_one = current_one[19] ? -current_one : current_one;
  wire [19:0] mag_two = current_two[19] ? -current_two : current_two;
  wire rd_unmapped = reg_rd &&
    !(reg_addr inside {8'he1, 8'he2, 8'he4, 8'he5, 8'he9, [8'heb:8'hee]});
  wire rsv_code = positive_selector == 5'h15 || positive_selector[4:3] == 2'h3 ||
    negative_selector == 5'h15 || negative_selector[4:3] == 2'h3;

  // Shadow writes so the checks see the same settings as the design
  always @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      {cond_a_q, db_one_q, db_two_q} <= 24'h0;
    else if (reg_wr)
      case (reg_addr)
        8'he1: cond_a_q <= reg_wdata;
        8'he4: db_one_q <= reg_wdata;
        8'he5: db_two_q <= reg_wdata;
        default: ;
      endcase

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Write to timebase, then two cycles to the copies
  sequence s_tb_wr;
    reg_wr && reg_addr == 8'he9;
  endsequence
  sequence s_big_one;
    sample_valid && mag_one >= {12'h0, db_one_q};
  endsequence

  a_tb_fields:
    assert property (s_tb_wr |=> ##1 tb_prescale == $past(reg_wdata[2:0], 2))
    else $error("prescaler copy wrong");
  a_tb_internal:
    assert property (tb_internal == (tb_prescale == 3'h7))
    else $error("internal clock select wrong");
  a_pair_one_on:
    assert property ((s_big_one and (cond_a_q[1:0] == 2'h0)) |=>
      acc_charge_one && acc_energy_one)
    else $error("pair one not accumulated");
  a_below_one:
    assert property (sample_valid && mag_one < {12'h0, db_one_q} |=> !acc_charge_one)
    else $error("pair one inside deadband");
  a_below_two:
    assert property (sample_valid && mag_two < {12'h0, db_two_q} |=> !acc_charge_two)
    else $error("pair two inside deadband");
  a_never_one:
    assert property (cond_a_q[1:0] == 2'h3 |=> !acc_charge_one && !acc_energy_one)
    else $error("disabled field accumulated");
  a_thr_with_acc:
    assert property (acc_charge_one || acc_charge_two |-> threshold_check)
    else $error("no threshold compare");
  a_rd_unmapped:
    assert property (rd_unmapped |=> reg_rdata == 8'h00 && !reg_hit)
    else $error("unmapped read answered");
  a_fast_codes:
    assert property (fast_mode |=> positive_selector == $past(fast_pos_code) &&
      negative_selector == $past(fast_neg_code))
    else $error("fast codes not used");
  a_fast_slot:
    assert property (fast_mode |-> ##2 !active_slot)
    else $error("slot moved in fast mode");
  a_reserved_off:
    assert property (selector_connect == !rsv_code)
    else $error("connect flag wrong");
endmodule

bind atm_regs atm_regs_checker i_chk
(
  .ref_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit,
  .sample_valid, .current_one, .current_two, .fast_mode, .fast_pos_code, .fast_neg_code,
  .acc_charge_one, .acc_energy_one, .acc_charge_two, .threshold_check, .tb_internal,
  .tb_prescale, .positive_selector, .negative_selector, .selector_connect, .active_slot
);

// ---- sim/atm_regs_bench.sv ----
// Purpose: directed bench for the accumulator, timebase and selector registers
// Assumes: inputs change 1 ns after the rising edge
// Notes: expected enables come from shadow settings kept here
`timescale 1ns/1ps
module atm_regs_bench;
  reg ref_clk, reset_n, reg_wr, reg_rd, sample_valid, fast_mode, slot_advance;
  reg [7:0] reg_addr, reg_wdata, ca, cb, d1, d2;
  reg [19:0] current_one, current_two;
  reg [4:0] fast_pos_code, fast_neg_code;
  wire [7:0] reg_rdata;
  wire [4:0] tb_divider, positive_selector, negative_selector;
  wire [2:0] tb_prescale;
  wire reg_hit, acc_charge_one, acc_energy_one, acc_charge_two, acc_energy_two;
  wire acc_sum_charge_one, acc_sum_charge_two, acc_sum_energy_one, acc_sum_energy_two;
  wire threshold_check, tb_internal, selector_connect, active_slot;
  integer n_fail, checks_done, i;

  atm_regs i_dut
  (
    .ref_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit,
    .sample_valid, .current_one, .current_two, .fast_mode, .fast_pos_code,
    .fast_neg_code, .slot_advance, .acc_charge_one, .acc_energy_one, .acc_charge_two,
    .acc_energy_two, .acc_sum_charge_one, .acc_sum_charge_two, .acc_sum_energy_one,
    .acc_sum_energy_two, .threshold_check, .tb_internal, .tb_prescale, .tb_divider,
    .positive_selector, .negative_selector, .selector_connect, .active_slot
  );

  ////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial
  begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end

  task tick;
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  task chk(input [11:0] g, input [11:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask

  // Strobe is dropped for a cycle so no signal is set twice in one step
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = d;
      tick;
      reg_wr = 0;
      tick;
      if (a == 8'he1) ca = d;
      if (a == 8'he2) cb = d;
      if (a == 8'he4) d1 = d;
      if (a == 8'he5) d2 = d;
    end
  endtask

  task rd(input [7:0] a, input [8:0] e);
    begin
      reg_rd = 1;
      reg_addr = a;
      tick;
      reg_rd = 0;
      chk({reg_hit, reg_rdata}, e);
      tick;
    end
  endtask

  function mp(input [7:0] a);
    mp = a inside {8'he1, 8'he2, 8'he4, 8'he5, 8'he9, [8'heb:8'hee]};
  endfunction

  // Zero current is neither sign, so signed fields block it
  function ok(input [1:0] c, input [19:0] v, input [7:0] d);
    ok = ((v[19] ? -v : v) >= {12'h0, d}) &&
      (c == 2'h0 || (c == 2'h1 && !v[19] && v != 0) || (c == 2'h2 && v[19]));
  endfunction

  // Valid stays high so samples can run back to back
  task samp(input [19:0] a, input [19:0] b);
    reg [5:0] e;
    begin
      sample_valid = 1;
      current_one = a;
      current_two = b;
      tick;
      e = {ok(ca[1:0], a, d1), ok(ca[3:2], b, d2), ok(cb[1:0], a, d1), ok(cb[3:2], b, d2),
        ok(cb[5:4], a, d1), ok(cb[7:6], b, d2)};
      chk({acc_charge_one, acc_energy_one, acc_charge_two, acc_energy_two, acc_sum_charge_one,
        acc_sum_charge_two, acc_sum_energy_one, acc_sum_energy_two, threshold_check},
        {e[5], e[5], e[4], e[4], e[3], e[2], e[1], e[0], |e});
    end
  endtask

  task test_done;
    begin
      $display("checks %0d fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // Watchdog well beyond the 175 cycles the tests need
  initial
  begin
    #100000;
    n_fail = n_fail + 1;
    test_done;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {reset_n, reg_wr, reg_rd, sample_valid, fast_mode, slot_advance} = 6'h00;
    {reg_addr, reg_wdata, ca, cb, d1, d2} = 48'h0;
    {current_one, current_two, fast_pos_code, fast_neg_code} = 50'h0;
    n_fail = 0;
    checks_done = 0;
    repeat (16) @(posedge ref_clk);
    #1;
    reset_n = 1;
    chk(tb_internal, 1'b1);
    // Reset values, holes in the map answer zero
    for (i = 8'he1; i < 8'hf0; i = i + 1)
      rd(i[7:0], mp(i[7:0]) ? {1'b1, i == 8'he9 ? 8'h07 : 8'h00} : 9'h0);
    // All ones everywhere: slot upper bits drop, holes stay empty
    for (i = 8'he1; i < 8'hf0; i = i + 1)
      wr(i[7:0], 8'hff);
    for (i = 8'he1; i < 8'hf0; i = i + 1)
      rd(i[7:0], mp(i[7:0]) ? {1'b1, i > 8'hea ? 8'h1f : 8'hff} : 9'h0);
    chk({tb_internal, tb_prescale, tb_divider}, 9'h1ff);
    wr(8'he9, 8'h3a);
    chk({tb_internal, tb_prescale, tb_divider}, {1'b0, 3'h2, 5'h07});
    // Slot selectors, slot two holds a reserved code
    wr(8'heb, 8'hf6);
    wr(8'hec, 8'h0c);
    wr(8'hed, 8'h15);
    wr(8'hee, 8'h17);
    chk({selector_connect, active_slot, positive_selector, negative_selector},
      {2'b10, 5'h0c, 5'h16});
    slot_advance = 1;
    tick;
    slot_advance = 0;
    tick;
    tick;
    chk({selector_connect, active_slot, positive_selector, negative_selector},
      {2'b01, 5'h17, 5'h15});
    // Fast mode ignores slot advance and uses its own codes
    fast_mode = 1;
    fast_pos_code = 5'h18;
    fast_neg_code = 5'h01;
    slot_advance = 1;
    tick;
    tick;
    tick;
    chk({selector_connect, active_slot, positive_selector, negative_selector},
      {2'b00, 5'h18, 5'h01});
    // Fast codes only change with fast mode stopped
    fast_mode = 0;
    slot_advance = 0;
    fast_pos_code = 5'h17;
    tick;
    fast_mode = 1;
    tick;
    tick;
    chk({selector_connect, active_slot, positive_selector, negative_selector},
      {2'b10, 5'h17, 5'h01});
    fast_mode = 0;
    slot_advance = 0;
    tick;
    // Every condition code against boundary currents of both deadbands
    wr(8'he4, 8'h03);
    wr(8'he5, 8'h80);
    for (i = 0; i < 5; i = i + 1)
    begin
      wr(8'he1, i < 4 ? {4'h0, i[1:0], i[1:0]} : 8'h06);
      wr(8'he2, i < 4 ? {4{i[1:0]}} : 8'h1b);
      samp(20'd5, -20'h80);
      samp(-20'd3, 20'h81);
      samp(20'd2, -20'h7f);
      samp(20'd0, 20'h0);
      sample_valid = 0;
      tick;
    end
    test_done;
  end
endmodule
